/* File: design/pzsp_pkg.sv */
// Package for the pipelined zero-turnaround SRAM port.
// Assumes a single rising-edge clock domain; used by pzsp_array and pzsp_port.
package pzsp_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int DEPTH = 262144;
  localparam int BURST_W = 2;
  localparam int PIPE_DEPTH = 2;
  localparam logic [1:0] BURST_LEN_M1 = 2'h3;
  localparam logic [1:0] CNT_RESET = 2'h0;
  localparam logic [17:0] ADDR_RESET = 18'h00000;
  localparam logic [17:0] DATA_RESET = 18'h00000;

  typedef enum logic [1:0] {
    PZSP_IDLE_E = 2'b00,
    PZSP_READ_E = 2'b01,
    PZSP_WRITE_E = 2'b10
  } pzsp_op_e;
endpackage : pzsp_pkg

/* File: design/pzsp_mem_if.sv */
// Interface between the port control and its storage array.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pzsp_mem_if #(
  parameter int AW = 18,
  parameter int DW = 18,
  parameter int NL = 2
);
  logic rd_en;
  logic wr_en;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [NL-1:0] lane_we;
  logic [DW-1:0] rdata;

  modport ctrl (
    output rd_en,
    output wr_en,
    output addr,
    output wdata,
    output lane_we,
    input rdata
  );
  modport mem (
    input rd_en,
    input wr_en,
    input addr,
    input wdata,
    input lane_we,
    output rdata
  );
endinterface : pzsp_mem_if

/* File: design/pzsp_array.sv */
// Storage array with per-lane write and registered read data.
// Assumes the control side only pulses rd_en or wr_en when the clock is live.
`timescale 1ns/1ps
module pzsp_array #(
  parameter int DEPTH = pzsp_pkg::DEPTH,
  parameter int LANE_W = pzsp_pkg::LANE_W,
  parameter int LANES = pzsp_pkg::LANES
) (
  input wire logic core_clk_i,
  pzsp_mem_if.mem mem
);
  logic [LANE_W*LANES-1:0] store [DEPTH];
  logic [LANE_W*LANES-1:0] rdata_q;

  // The array has no reset, so stored data survive any control reset.
  always_ff @(posedge core_clk_i)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (mem.wr_en && mem.lane_we[i])
      begin
        store[mem.addr][i*LANE_W +: LANE_W] <= mem.wdata[i*LANE_W +: LANE_W];
      end
    end
    if (mem.rd_en)
    begin
      rdata_q <= store[mem.addr];
    end
  end

  assign mem.rdata = rdata_q;
endmodule : pzsp_array

/* File: design/pzsp_port.sv */
// Top of the pipelined zero-turnaround SRAM port.
// Assumes all inputs are synchronous to core_clk_i except rstn_i.
`timescale 1ns/1ps
module pzsp_port #(
  parameter int ADDR_W = pzsp_pkg::ADDR_W,
  parameter int DATA_W = pzsp_pkg::DATA_W,
  parameter int LANES = pzsp_pkg::LANES,
  parameter int DEPTH = pzsp_pkg::DEPTH
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic clock_enable_n_i,
  input wire logic advance_or_load_i,
  input wire logic read_write_select_i,
  input wire logic chip_select_a_n_i,
  input wire logic chip_select_b_n_i,
  input wire logic chip_select_pos_i,
  input wire logic [LANES-1:0] byte_write_enables_n_i,
  input wire logic burst_order_select_i,
  input wire logic sleep_request_i,
  input wire logic output_enable_n_i,
  input wire logic [ADDR_W-1:0] address_inputs_i,
  input wire logic [DATA_W-1:0] data_pins_i,
  output logic [DATA_W-1:0] data_pins_o,
  output logic data_pins_oe_o
);
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [ADDR_W-1:0] base;
    logic [1:0] cnt;
    logic burst_live;
    logic burst_wr;
    pzsp_pkg::pzsp_op_e op1;
    logic [ADDR_W-1:0] addr1;
    logic [LANES-1:0] we1;
    pzsp_pkg::pzsp_op_e op2;
    logic [ADDR_W-1:0] addr2;
    logic [LANES-1:0] we2;
    logic drive;
  } pzsp_state_s;

  // Idle pipeline with the data pins floated.
  localparam pzsp_state_s STATE_RESET = '{
    base: pzsp_pkg::ADDR_RESET,
    cnt: pzsp_pkg::CNT_RESET,
    burst_live: 1'b0,
    burst_wr: 1'b0,
    op1: pzsp_pkg::PZSP_IDLE_E,
    addr1: pzsp_pkg::ADDR_RESET,
    we1: '0,
    op2: pzsp_pkg::PZSP_IDLE_E,
    addr2: pzsp_pkg::ADDR_RESET,
    we2: '0,
    drive: 1'b0
  };

  pzsp_state_s s_q;
  pzsp_state_s s_d;
  logic live;
  logic selected;

  pzsp_mem_if #(.AW(ADDR_W), .DW(DATA_W), .NL(LANES)) mem_if ();

  pzsp_array #(
    .DEPTH(DEPTH),
    .LANE_W(DATA_W / LANES),
    .LANES(LANES)
  ) u_array (
    .core_clk_i(core_clk_i),
    .mem(mem_if)
  );

  ////////////////////////////////////////////////////////////////////////
  // Burst offset for a start offset, count and order.
  function automatic logic [1:0] burst_ofs(
    input logic [1:0] start,
    input logic [1:0] cnt,
    input logic ilv
  );
    if (ilv)
    begin
      burst_ofs = start ^ cnt;
    end
    else
    begin
      burst_ofs = start + cnt;
    end
  endfunction : burst_ofs

  // Active-high lane enables, all off unless writing.
  function automatic logic [LANES-1:0] lane_enables(
    input logic [LANES-1:0] bwe_n,
    input logic wr
  );
    if (wr)
    begin
      lane_enables = ~bwe_n;
    end
    else
    begin
      lane_enables = '0;
    end
  endfunction : lane_enables

  // True for a read held in a pipeline stage.
  function automatic logic op_is_read(input pzsp_pkg::pzsp_op_e op);
    op_is_read = (op == pzsp_pkg::PZSP_READ_E);
  endfunction : op_is_read

  ////////////////////////////////////////////////////////////////////////
  // edge gating
  assign live = !clock_enable_n_i && !sleep_request_i;

  assign selected = !chip_select_a_n_i && !chip_select_b_n_i &&
    chip_select_pos_i;

  always_comb
  begin
    logic [1:0] ncnt;
    logic [1:0] ofs;
    ncnt = 2'h0;
    ofs = 2'h0;
    s_d = s_q;
    if (live)
    begin
      s_d.op2 = s_q.op1;
      s_d.addr2 = s_q.addr1;
      s_d.we2 = s_q.we1;
      s_d.op1 = pzsp_pkg::PZSP_IDLE_E;
      s_d.we1 = '0;
      if (!advance_or_load_i && selected)
      begin
        s_d.base = address_inputs_i;
        s_d.cnt = pzsp_pkg::CNT_RESET;
        s_d.burst_live = 1'b1;
        s_d.burst_wr = !read_write_select_i;
        s_d.addr1 = address_inputs_i;
        s_d.op1 = read_write_select_i ? pzsp_pkg::PZSP_READ_E :
          pzsp_pkg::PZSP_WRITE_E;
        s_d.we1 = lane_enables(byte_write_enables_n_i, !read_write_select_i);
      end
      else if (!advance_or_load_i)
      begin
        s_d.burst_live = 1'b0;
      end
      else if (s_q.burst_live)
      begin
        ncnt = s_q.cnt + 2'h1;
        s_d.cnt = ncnt;
        ofs = burst_ofs(s_q.base[1:0], ncnt, burst_order_select_i);
        s_d.addr1 = {s_q.base[ADDR_W-1:2], ofs};
        s_d.op1 = s_q.burst_wr ? pzsp_pkg::PZSP_WRITE_E :
          pzsp_pkg::PZSP_READ_E;
        s_d.we1 = lane_enables(byte_write_enables_n_i, s_q.burst_wr);
      end
      s_d.drive = op_is_read(s_q.op2) && !output_enable_n_i;
    end
  end

  // The array is read and written at the data edge of each access, so a
  // read right after a write to the same word sees the new data.
  always_comb
  begin
    mem_if.rd_en = live && op_is_read(s_q.op2);
    mem_if.wr_en = live && (s_q.op2 == pzsp_pkg::PZSP_WRITE_E);
    mem_if.addr = s_q.addr2;
    mem_if.wdata = data_pins_i;
    mem_if.lane_we = s_q.we2;
  end

  ////////////////////////////////////////////////////////////////////////
  // floated from reset
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s_q <= STATE_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign data_pins_o = mem_if.rdata;
  assign data_pins_oe_o = s_q.drive;
endmodule : pzsp_port

/* File: dv/pzsp_bus_model.sv */
// Far end of the data pins: the master drives write data.
// Assumes one clock; a released wire shows its last level inverted.
`timescale 1ns/1ps
module pzsp_bus_model (
  input wire logic clk_i,
  input wire logic dev_oe_i,
  input wire logic [17:0] dev_i,
  input wire logic mst_oe_i,
  input wire logic [17:0] mst_i,
  output logic [17:0] bus_o
);
  logic [17:0] last_q = 18'h00000;
  always_comb bus_o = dev_oe_i ? dev_i : (mst_oe_i ? mst_i : ~last_q);
  always_ff @(posedge clk_i) last_q <= bus_o;
endmodule : pzsp_bus_model

/* File: dv/pzsp_port_assertions.sv */
// Drive timing checks of the port outputs.
// Assumes it is bound into pzsp_port.
`timescale 1ns/1ps
module pzsp_port_chk (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic clock_enable_n_i,
  input wire logic sleep_request_i,
  input wire logic advance_or_load_i,
  input wire logic read_write_select_i,
  input wire logic chip_select_a_n_i,
  input wire logic chip_select_b_n_i,
  input wire logic chip_select_pos_i,
  input wire logic output_enable_n_i,
  input wire logic data_pins_oe_o
);
  wire oe = data_pins_oe_o;
  wire act = !clock_enable_n_i && !sleep_request_i;
  wire adv = act && advance_or_load_i;
  wire ld = act && !advance_or_load_i;
  wire sel = !chip_select_a_n_i && !chip_select_b_n_i && chip_select_pos_i;
  wire rok = act && !output_enable_n_i;
  ////////////////////////////////
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_rd; ld && sel && read_write_select_i; endsequence
  sequence s_wr; ld && sel && !read_write_select_i; endsequence
  sequence s_ds; ld && !sel; endsequence
  sequence s_two; act ##1 act; endsequence
  property p_hold; clock_enable_n_i |=> $stable(oe); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_slp; sleep_request_i |=> $stable(oe); endproperty
  a_slp: assert property (p_slp) else $error("sleep");
  property p_oen; act && output_enable_n_i |=> !oe; endproperty
  a_oen: assert property (p_oen) else $error("oe");
  property p_rd; s_rd ##1 act ##1 rok |=> oe; endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_pnd; s_rd ##1 s_ds ##1 rok |=> oe; endproperty
  a_pnd: assert property (p_pnd) else $error("pending");
  property p_brd; s_rd ##1 adv ##1 act ##1 rok |=> oe; endproperty
  a_brd: assert property (p_brd) else $error("burst");
  property p_bwr;
    s_wr ##1 (adv && read_write_select_i) ##1 s_two |=> !oe;
  endproperty
  a_bwr: assert property (p_bwr) else $error("burst write");
  property p_ds; (s_ds or s_wr) ##1 s_two |=> !oe; endproperty
  a_ds: assert property (p_ds) else $error("float");
endmodule : pzsp_port_chk
bind pzsp_port pzsp_port_chk i_pzsp_port_chk (.*);

/* File: dv/tb_top.sv */
// Random bench; a queue model checks the port at every rising edge out of reset.
// Assumes the port, its checker and the bus model are compiled first.
`timescale 1ns/1ps
module tb_top;
  logic core_clk_i = 1'h0, rstn_i = 1'h0, clock_enable_n_i = 1'h1;
  logic advance_or_load_i = 1'h0, read_write_select_i = 1'h0;
  logic chip_select_a_n_i = 1'h1, chip_select_b_n_i = 1'h1;
  logic chip_select_pos_i = 1'h0, burst_order_select_i = 1'h0;
  logic sleep_request_i = 1'h0, output_enable_n_i = 1'h0, mst_oe = 1'h0;
  logic data_pins_oe_o, e_oe = 1'h0;
  logic [1:0] byte_write_enables_n_i = 2'h3;
  logic [17:0] address_inputs_i = 18'h00000, data_pins_i, data_pins_o;
  logic [17:0] mst_d = 18'h00000, e_d, m;
  logic [17:0] mem [int];
  int fails = 0, check_count = 0, seed = 18, s, op, a, bb, bc, bk;
  int pq [$] = '{0, 0};
  always #4 core_clk_i = ~core_clk_i;
  pzsp_port i_pzsp_port (.*);
  pzsp_bus_model i_pzsp_bus_model (.clk_i(core_clk_i), .dev_i(data_pins_o),
    .dev_oe_i(data_pins_oe_o), .mst_i(mst_d), .mst_oe_i(mst_oe),
    .bus_o(data_pins_i));
  task automatic cmp_data(input logic [17:0] got, input logic [17:0] exp);
    check_count++;
    fails += got !== exp;
    if (got !== exp)
      $display("wrong value at %0t: %h %h", $time, got, exp);
  endtask : cmp_data
  task automatic cmp_oe(input logic got, input logic exp);
    cmp_data({17'h0, got}, {17'h0, exp});
  endtask : cmp_oe
  task automatic conclude();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  ////////////////////////////////
  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      pq = '{0, 0};
      bk = 0;
      e_oe = 1'h0;
      mst_oe <= 1'h0;
    end
    else
    begin
      cmp_oe(data_pins_oe_o, e_oe);
      if (e_oe)
        cmp_data(data_pins_o, e_d);
      if (!clock_enable_n_i && !sleep_request_i)
      begin
        op = pq.pop_front();
        a = op & 'h3ffff;
        m = {{9{!op[19]}}, {9{!op[18]}}};
        if (op[21])
          mem[a] = (mem.exists(a) ? mem[a] : 18'hx) & ~m | data_pins_i & m;
        e_oe = op[20] && !output_enable_n_i;
        e_d = mem.exists(a) ? mem[a] : 18'hx;
        if (!advance_or_load_i)
        begin
          bk = chip_select_a_n_i || chip_select_b_n_i || !chip_select_pos_i
            ? 0 : 2 - read_write_select_i;
          bb = address_inputs_i;
          bc = 0;
        end
        else
          bc++;
        a = burst_order_select_i ? bb ^ bc : bb + bc;
        pq.push_back(bk << 20 | byte_write_enables_n_i << 18 |
          bb & 'h3fffc | a & 3);
        mst_oe <= pq[0][21];
        mst_d <= $random(seed);
      end
    end
  end
  initial
  begin
    for (int ph = 0; ph < 2; ph++)
    begin
      rstn_i <= 1'h0;
      burst_order_select_i <= ph[0];
      repeat (8) @(posedge core_clk_i);
      rstn_i <= 1'h1;
      repeat (3000)
      begin
        @(posedge core_clk_i);
        s = $random(seed);
        clock_enable_n_i <= s[2:0] == 0;
        sleep_request_i <= s[31:28] == 0;
        output_enable_n_i <= s[27:25] == 0;
        {advance_or_load_i, read_write_select_i,
          byte_write_enables_n_i} <= s[6:3];
        address_inputs_i <= {s[11], 13'h0000, s[10:7]};
        {chip_select_a_n_i, chip_select_b_n_i, chip_select_pos_i} <=
          s[24:22] == 0 ? s[21:19] : 3'h1;
      end
    end
    conclude();
  end
  initial
  begin
    #100000;
    fails++;
    conclude();
  end
endmodule : tb_top
